// file: rtl/ppc_pkg.sv
/*
  Constants, field tables and decode helpers for the port PHY control
  register bank and its mirrored views.
  Assumes byte addresses on an 8-bit register address, 16-bit registers
  on even addresses, and byte enables where lane 1 carries bits 15:8.
*/
package ppc_pkg;

  // Register byte offsets
  localparam logic [7:0] PPC_OFF_BMC = 8'hE4;
  localparam logic [7:0] PPC_OFF_ADV = 8'hEC;
  localparam logic [7:0] PPC_OFF_LPA = 8'hEE;
  localparam logic [7:0] PPC_OFF_CTL = 8'hF6;
  localparam logic [7:0] PPC_OFF_STS = 8'hF8;

  // Stored field indices
  localparam int PPC_NF          = 15;
  localparam int PPC_F_LED_OFF   = 0;
  localparam int PPC_F_TX_DIS    = 1;
  localparam int PPC_F_MDIX_OFF  = 2;
  localparam int PPC_F_MDI_FORCE = 3;
  localparam int PPC_F_AN_EN     = 4;
  localparam int PPC_F_SPEED     = 5;
  localparam int PPC_F_DUPLEX    = 6;
  localparam int PPC_F_ADV_PAUSE = 7;
  localparam int PPC_F_ADV_100F  = 8;
  localparam int PPC_F_ADV_100H  = 9;
  localparam int PPC_F_ADV_10F   = 10;
  localparam int PPC_F_ADV_10H   = 11;

  typedef int ppc_pos_t [PPC_NF];

  // Bit position of each field in each view; -1 means absent from that view
  localparam ppc_pos_t PPC_CTL_POS = '{15, 14, 10, 9, 7, 6, 5, 4, 3, 2, 1, 0, 12, 11, 8};
  localparam ppc_pos_t PPC_BMC_POS = '{0, 1, 3, 4, 12, 13, 8, -1, -1, -1, -1, -1, -1, -1, -1};
  localparam ppc_pos_t PPC_ADV_POS = '{-1, -1, -1, -1, -1, -1, -1, 10, 8, 7, 6, 5, -1, -1, -1};

  localparam logic [14:0] PPC_FIELD_RST = 15'h0FF0;

  localparam int PPC_CTL_RESTART = 13;
  localparam int PPC_BMC_RESTART = 9;

  // Partner ability bit i sits at this position of the partner view
  localparam int PPC_ABIL_POS [5] = '{5, 6, 7, 8, 10};

  localparam logic [4:0] PPC_SELECTOR = 5'h01;
  localparam int PPC_STS_SPEED  = 10;
  localparam int PPC_STS_DUPLEX = 9;
  localparam int PPC_STS_MDI    = 7;
  localparam int PPC_STS_AN     = 6;
  localparam int PPC_STS_LINK   = 5;

  function automatic logic ppc_hit(input logic [7:0] addr, input logic [7:0] off);
    ppc_hit = (addr[7:1] == off[7:1]);
  endfunction

  function automatic logic ppc_lane(input logic [1:0] be, input int pos);
    ppc_lane = (pos >= 8) ? be[1] : be[0];
  endfunction

endpackage

// file: rtl/ppc_restart.sv
/*
  Negotiation restart request holder: a stored request bit and a one-cycle
  pulse toward the negotiation logic.
  Assumes the negotiation logic answers with an accept strobe on clk.
*/
`timescale 1ns/100ps
`default_nettype none
module ppc_restart (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic set_req,
  input  wire logic accept,
  output var  logic req,
  output var  logic pulse
);

  // A new request in the accept cycle wins, so it is never lost
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req <= 1'b0;
    end else if (clk_en) begin
      if (set_req) begin
        req <= 1'b1;
      end else if (accept) begin
        req <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse <= 1'b0;
    end else if (clk_en) begin
      pulse <= set_req;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ppc_readback.sv
/*
  Read view builder: assembles the control, basic control, advertisement,
  partner ability and status views from shared storage and PHY inputs and selects one.
  Assumes all inputs are on the register clock.
*/
`timescale 1ns/100ps
`default_nettype none
module ppc_readback
  import ppc_pkg::*;
(
  input  wire logic [7:0]  addr,
  input  wire logic [14:0] fields,
  input  wire logic        restart_req,
  input  wire logic [4:0]  partner,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  input  wire logic        mdi_state,
  input  wire logic        an_done,
  input  wire logic        link_good,
  output logic      [15:0] rd_data
);

  logic [15:0] ctl_v;
  logic [15:0] bmc_v;
  logic [15:0] adv_v;
  logic [15:0] lpa_v;
  logic [15:0] sts_v;

  always_comb begin
    ctl_v = 16'h0000;
    bmc_v = 16'h0000;
    adv_v = {11'h000, PPC_SELECTOR};
    lpa_v = {11'h000, PPC_SELECTOR};
    sts_v = {11'h000, partner};
    for (int i = 0; i < PPC_NF; i++) begin
      ctl_v[PPC_CTL_POS[i]] = fields[i];
      if (PPC_BMC_POS[i] >= 0) begin
        bmc_v[PPC_BMC_POS[i]] = fields[i];
      end
      if (PPC_ADV_POS[i] >= 0) begin
        adv_v[PPC_ADV_POS[i]] = fields[i];
      end
    end
    ctl_v[PPC_CTL_RESTART] = restart_req;
    bmc_v[PPC_BMC_RESTART] = restart_req;
    for (int j = 0; j < 5; j++) begin
      lpa_v[PPC_ABIL_POS[j]] = partner[j];
    end
    sts_v[PPC_STS_SPEED]  = speed_100;
    sts_v[PPC_STS_DUPLEX] = full_duplex;
    sts_v[PPC_STS_MDI]    = mdi_state;
    sts_v[PPC_STS_AN]     = an_done;
    sts_v[PPC_STS_LINK]   = link_good;
    if (ppc_hit(addr, PPC_OFF_CTL)) begin
      rd_data = ctl_v;
    end else if (ppc_hit(addr, PPC_OFF_BMC)) begin
      rd_data = bmc_v;
    end else if (ppc_hit(addr, PPC_OFF_ADV)) begin
      rd_data = adv_v;
    end else if (ppc_hit(addr, PPC_OFF_LPA)) begin
      rd_data = lpa_v;
    end else if (ppc_hit(addr, PPC_OFF_STS)) begin
      rd_data = sts_v;
    end else begin
      rd_data = 16'h0000;
    end
  end

endmodule
`default_nettype wire

// file: rtl/ppc_ctrl.sv
/*
  Port PHY control register bank. One set of flops is shared by the port
  control view and its mirrors in the PHY basic control and advertisement
  views, and drives the PHY control outputs and the port LED pins.
  Assumes a simple register port on clk (address, read and write strobes,
  byte enables) and PHY status and LED logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - Control bit 15 set drives all four port LED pins high.
// - Control bit 14 set disables the port transmitter.
// - Writing one to bit 13 restarts auto-negotiation.
// - Bit 10 set disables automatic crossover; reset value zero keeps it on.
// - With crossover off, bit 9 one forces MDI, zero forces MDI-X.
// - Bit 7 enables negotiation, resets one; cleared, bits 6 and 5 decide.
// - Bit 6 forces 100BT when one, 10BT when zero; resets to one.
// - Bit 5 forces full or half duplex, also on failed negotiation; resets one.
// - Bit 4 advertises pause ability; resets to one.
// - Bit 3 advertises 100BT full duplex; resets to one.
// - Bit 2 advertises 100BT half duplex; resets to one.
// - Bit 1 advertises 10BT full duplex; resets to one.
// - Bit 0 advertises 10BT half duplex; resets to one.
// - Control bits 15, 14, 13, 10, 9, 7, 6 and 5 share storage with the PHY basic control register fields.
// - Advertisement bits share storage with the advertisement register; both views update.
// - Bits 12, 11 and 8 are reserved and reset to zero.
// - Status view reports partner abilities and resolved speed and duplex.
module ppc_ctrl
  import ppc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_be,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [3:0]  led_drive,
  output logic             port_led_zero,
  output logic             port_led_one,
  output logic             port_led_two,
  output logic             port_led_three,
  input  wire logic        an_restart_ack,
  input  wire logic [4:0]  partner_ability,
  input  wire logic        link_speed_100,
  input  wire logic        link_full_duplex,
  input  wire logic        mdi_status,
  input  wire logic        an_done,
  input  wire logic        link_good,
  output logic             tx_disable,
  output logic             an_restart_pulse,
  output logic             auto_mdix_disable,
  output logic             force_mdi,
  output logic             an_enable,
  output logic             force_speed_100,
  output logic             force_full_duplex,
  output logic             adv_pause,
  output logic             adv_100_full,
  output logic             adv_100_half,
  output logic             adv_10_full,
  output logic             adv_10_half
);

  logic [14:0] fields;
  logic        wr_ctl;
  logic        wr_bmc;
  logic        wr_adv;
  logic        restart_set;
  logic        restart_req;
  logic [15:0] next_rdata;
  logic [3:0]  led_q;

  assign wr_ctl = reg_wr && ppc_hit(reg_addr, PPC_OFF_CTL);
  assign wr_bmc = reg_wr && ppc_hit(reg_addr, PPC_OFF_BMC);
  assign wr_adv = reg_wr && ppc_hit(reg_addr, PPC_OFF_ADV);

  // One flop per field; every view that carries the field writes the same flop
  for (genvar i = 0; i < PPC_NF; i++) begin : g_field
    logic wr_b;
    logic wr_a;
    logic val_b;
    logic val_a;
    if (PPC_BMC_POS[i] >= 0) begin : g_b
      assign wr_b  = wr_bmc && ppc_lane(reg_be, PPC_BMC_POS[i]);
      assign val_b = reg_wdata[PPC_BMC_POS[i]];
    end else begin : g_nb
      assign wr_b  = 1'b0;
      assign val_b = 1'b0;
    end
    if (PPC_ADV_POS[i] >= 0) begin : g_a
      assign wr_a  = wr_adv && ppc_lane(reg_be, PPC_ADV_POS[i]);
      assign val_a = reg_wdata[PPC_ADV_POS[i]];
    end else begin : g_na
      assign wr_a  = 1'b0;
      assign val_a = 1'b0;
    end
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        fields[i] <= PPC_FIELD_RST[i];
      end else if (clk_en) begin
        if (wr_ctl && ppc_lane(reg_be, PPC_CTL_POS[i])) begin
          fields[i] <= reg_wdata[PPC_CTL_POS[i]];
        end else if (wr_b) begin
          fields[i] <= val_b;
        end else if (wr_a) begin
          fields[i] <= val_a;
        end
      end
    end
  end

  // Only a written one requests a restart; writing zero is a no-op
  assign restart_set = (wr_ctl && reg_be[1] && reg_wdata[PPC_CTL_RESTART])
                    || (wr_bmc && reg_be[1] && reg_wdata[PPC_BMC_RESTART]);

  ppc_restart u_restart (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .set_req (restart_set),
    .accept  (an_restart_ack),
    .req     (restart_req),
    .pulse   (an_restart_pulse)
  );

  ppc_readback u_readback (
    .addr        (reg_addr),
    .fields      (fields),
    .restart_req (restart_req),
    .partner     (partner_ability),
    .speed_100   (link_speed_100),
    .full_duplex (link_full_duplex),
    .mdi_state   (mdi_status),
    .an_done     (an_done),
    .link_good   (link_good),
    .rd_data     (next_rdata)
  );

  // Read data is captured one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Blanking forces the pins high, which is the LED off level
  for (genvar k = 0; k < 4; k++) begin : g_led
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        led_q[k] <= 1'b1;
      end else if (clk_en) begin
        led_q[k] <= fields[PPC_F_LED_OFF] | led_drive[k];
      end
    end
  end

  assign port_led_zero  = led_q[0];
  assign port_led_one   = led_q[1];
  assign port_led_two   = led_q[2];
  assign port_led_three = led_q[3];

  assign tx_disable        = fields[PPC_F_TX_DIS];
  assign auto_mdix_disable = fields[PPC_F_MDIX_OFF];
  assign force_mdi         = fields[PPC_F_MDI_FORCE];
  assign an_enable         = fields[PPC_F_AN_EN];
  assign force_speed_100   = fields[PPC_F_SPEED];
  assign force_full_duplex = fields[PPC_F_DUPLEX];
  assign adv_pause         = fields[PPC_F_ADV_PAUSE];
  assign adv_100_full      = fields[PPC_F_ADV_100F];
  assign adv_100_half      = fields[PPC_F_ADV_100H];
  assign adv_10_full       = fields[PPC_F_ADV_10F];
  assign adv_10_half       = fields[PPC_F_ADV_10H];

  property p_led_blank;
    @(posedge clk) disable iff (sys_rst)
    clk_en && fields[PPC_F_LED_OFF] |=> led_q == 4'hF;
  endproperty
  a_led_blank: assert property (p_led_blank) else $error("LEDs not blanked");

  property p_led_pass;
    @(posedge clk) disable iff (sys_rst)
    clk_en && !fields[PPC_F_LED_OFF] |=> led_q == $past(led_drive);
  endproperty
  a_led_pass: assert property (p_led_pass) else $error("LED drive lost");

  property p_txdis_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[1] |=> tx_disable == $past(reg_wdata[14]);
  endproperty
  a_txdis_wr: assert property (p_txdis_wr) else $error("tx disable not written");

  property p_mdix_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[1] |=> auto_mdix_disable == $past(reg_wdata[10]);
  endproperty
  a_mdix_wr: assert property (p_mdix_wr) else $error("crossover disable not written");

  property p_mdi_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[1] |=> force_mdi == $past(reg_wdata[9]);
  endproperty
  a_mdi_wr: assert property (p_mdi_wr) else $error("forced wiring not written");

  property p_an_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> an_enable == $past(reg_wdata[7]);
  endproperty
  a_an_wr: assert property (p_an_wr) else $error("negotiation enable not written");

  property p_speed_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> force_speed_100 == $past(reg_wdata[6]);
  endproperty
  a_speed_wr: assert property (p_speed_wr) else $error("forced speed not written");

  property p_duplex_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> force_full_duplex == $past(reg_wdata[5]);
  endproperty
  a_duplex_wr: assert property (p_duplex_wr) else $error("forced duplex not written");

  property p_pause_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> adv_pause == $past(reg_wdata[4]);
  endproperty
  a_pause_wr: assert property (p_pause_wr) else $error("pause advert not written");

  property p_a100f_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> adv_100_full == $past(reg_wdata[3]);
  endproperty
  a_a100f_wr: assert property (p_a100f_wr) else $error("100 full advert not written");

  property p_a100h_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> adv_100_half == $past(reg_wdata[2]);
  endproperty
  a_a100h_wr: assert property (p_a100h_wr) else $error("100 half advert not written");

  property p_a10f_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> adv_10_full == $past(reg_wdata[1]);
  endproperty
  a_a10f_wr: assert property (p_a10f_wr) else $error("10 full advert not written");

  property p_a10h_wr;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_ctl && reg_be[0] |=> adv_10_half == $past(reg_wdata[0]);
  endproperty
  a_a10h_wr: assert property (p_a10h_wr) else $error("10 half advert not written");

  property p_restart_pulse;
    @(posedge clk) disable iff (sys_rst)
    clk_en && restart_set |=> an_restart_pulse && restart_req;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse) else $error("no restart");

  property p_restart_once;
    @(posedge clk) disable iff (sys_rst)
    clk_en && an_restart_pulse && !restart_set |=> !an_restart_pulse;
  endproperty
  a_restart_once: assert property (p_restart_once) else $error("pulse too long");

  property p_restart_clear;
    @(posedge clk) disable iff (sys_rst)
    clk_en && restart_req && an_restart_ack && !restart_set |=> !restart_req;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart not cleared");

  property p_bmc_mirror;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_bmc && reg_be == 2'h3
    |=> {an_enable, force_speed_100, force_full_duplex, force_mdi, auto_mdix_disable}
        == $past({reg_wdata[12], reg_wdata[13], reg_wdata[8], reg_wdata[4], reg_wdata[3]});
  endproperty
  a_bmc_mirror: assert property (p_bmc_mirror) else $error("basic view mismatch");

  property p_adv_mirror;
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_adv && reg_be == 2'h3
    |=> {adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half}
        == $past({reg_wdata[10], reg_wdata[8:5]});
  endproperty
  a_adv_mirror: assert property (p_adv_mirror) else $error("advert view mismatch");

  property p_ctl_read;
    @(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && ppc_hit(reg_addr, PPC_OFF_CTL) && !reg_wr
    |=> reg_rvalid && reg_rdata[7:0] == $past({an_enable, force_speed_100,
        force_full_duplex, adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half});
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control readback wrong");

  property p_sts_read;
    @(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && ppc_hit(reg_addr, PPC_OFF_STS)
    |=> reg_rdata[4:0] == $past(partner_ability)
        && reg_rdata[10:9] == $past({link_speed_100, link_full_duplex});
  endproperty
  a_sts_read: assert property (p_sts_read) else $error("status readback wrong");

endmodule
`default_nettype wire

// file: verif/tb_top.sv
/*
  Self-checking bench for the port PHY control register bank.
  Assumes ppc_pkg and ppc_ctrl are compiled first; the bench drives every port itself.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import ppc_pkg::*;
  ;
  logic        clk              = 1'b0;
  logic        sys_rst          = 1'b1;
  logic        clk_en           = 1'b1;
  logic [7:0]  reg_addr         = 8'h00;
  logic        reg_wr           = 1'b0;
  logic        reg_rd           = 1'b0;
  logic [1:0]  reg_be           = 2'h0;
  logic [15:0] reg_wdata        = 16'h0000;
  logic [3:0]  led_drive        = 4'h5;
  logic        an_restart_ack   = 1'b0;
  logic [4:0]  partner_ability  = 5'h00;
  logic        link_speed_100   = 1'b0;
  logic        link_full_duplex = 1'b0;
  logic        mdi_status       = 1'b0;
  logic        an_done          = 1'b0;
  logic        link_good        = 1'b0;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        port_led_zero, port_led_one, port_led_two, port_led_three;
  logic        tx_disable, an_restart_pulse, auto_mdix_disable, force_mdi, an_enable;
  logic        force_speed_100, force_full_duplex, adv_pause, adv_100_full;
  logic        adv_100_half, adv_10_full, adv_10_half;
  logic [10:0] outs;
  logic [3:0]  leds;
  int          miscompares      = 0;
  int          total_checks     = 0;

  always #50 clk = ~clk;

  assign outs = {tx_disable, auto_mdix_disable, force_mdi, an_enable, force_speed_100,
                 force_full_duplex, adv_pause, adv_100_full, adv_100_half, adv_10_full,
                 adv_10_half};
  assign leds = {port_led_three, port_led_two, port_led_one, port_led_zero};

  ppc_ctrl dut (
    .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .led_drive(led_drive), .port_led_zero(port_led_zero),
    .port_led_one(port_led_one), .port_led_two(port_led_two),
    .port_led_three(port_led_three), .an_restart_ack(an_restart_ack),
    .partner_ability(partner_ability), .link_speed_100(link_speed_100),
    .link_full_duplex(link_full_duplex), .mdi_status(mdi_status), .an_done(an_done),
    .link_good(link_good), .tx_disable(tx_disable), .an_restart_pulse(an_restart_pulse),
    .auto_mdix_disable(auto_mdix_disable), .force_mdi(force_mdi), .an_enable(an_enable),
    .force_speed_100(force_speed_100), .force_full_duplex(force_full_duplex),
    .adv_pause(adv_pause), .adv_100_full(adv_100_full), .adv_100_half(adv_100_half),
    .adv_10_full(adv_10_full), .adv_10_half(adv_10_half)
  );

  task automatic close_out;
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Basic control and advertisement images of a control word
  function automatic logic [15:0] to_bmc(input logic [15:0] v);
    to_bmc = {2'b00, v[6], v[7], 2'b00, v[13], v[5], 3'b000, v[9], v[10], 1'b0, v[14], v[15]};
  endfunction

  function automatic logic [15:0] to_adv(input logic [15:0] v);
    to_adv = {5'h00, v[4], 1'b0, v[3:0], 5'h01};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_be    <= be;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read and compare; the answer is due just after the taking edge, with no wait cycle
  task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4) begin
      miscompares++;
      $display("[ERR] %0t read answer missing", $time);
      close_out();
    end
    check(16'(n), 16'h0000);
    check(reg_rdata, exp);
  endtask

  task automatic s_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(leds, 16'h000F);
    check(outs, 16'h00FF);
    check(an_restart_pulse, 1'b0);
    @(posedge clk);
    sys_rst <= 1'b0;
    rdc(PPC_OFF_CTL, 16'h00FF);
    rdc(PPC_OFF_BMC, 16'h3100);
    rdc(PPC_OFF_ADV, 16'h05E1);
  endtask

  task automatic s_fields;
    logic [15:0] tbl [4];
    tbl = '{16'h4600, 16'h00AA, 16'h0055, 16'h5F7F};
    foreach (tbl[i]) begin
      wr(PPC_OFF_CTL, 2'h3, tbl[i]);
      check(outs, {tbl[i][14], tbl[i][10], tbl[i][9], tbl[i][7:0]});
      rdc(PPC_OFF_CTL, tbl[i]);
      rdc(PPC_OFF_BMC, to_bmc(tbl[i]));
      rdc(PPC_OFF_ADV, to_adv(tbl[i]));
    end
  endtask

  // Writes through the mirrors and single byte lanes, bits outside the fields ignored
  task automatic s_mirror;
    wr(PPC_OFF_BMC, 2'h3, 16'hA10A);
    rdc(PPC_OFF_CTL, 16'h5D7F);
    wr(PPC_OFF_ADV, 2'h3, 16'h061F);
    rdc(PPC_OFF_CTL, 16'h5D70);
    rdc(PPC_OFF_ADV, 16'h0401);
    check(outs[4:0], 16'h0010);
    wr(PPC_OFF_CTL, 2'h1, 16'hFFFF);
    rdc(PPC_OFF_CTL, 16'h5DFF);
    wr(PPC_OFF_CTL, 2'h2, 16'h0000);
    rdc(PPC_OFF_CTL, 16'h00FF);
  endtask

  task automatic s_led;
    check(leds, 16'h0005);
    wr(PPC_OFF_CTL, 2'h3, 16'h8000);
    @(posedge clk);
    #1;
    check(leds, 16'h000F);
    @(posedge clk);
    led_drive <= 4'hA;
    repeat (2) @(posedge clk);
    #1;
    check(leds, 16'h000F);
    wr(PPC_OFF_CTL, 2'h3, 16'h0000);
    @(posedge clk);
    #1;
    check(leds, 16'h000A);
  endtask

  task automatic s_restart;
    wr(PPC_OFF_CTL, 2'h3, 16'h2000);
    check(an_restart_pulse, 1'b1);
    @(posedge clk);
    #1;
    check(an_restart_pulse, 1'b0);
    rdc(PPC_OFF_BMC, 16'h0200);
    wr(PPC_OFF_CTL, 2'h3, 16'h0000);
    rdc(PPC_OFF_CTL, 16'h2000);
    @(posedge clk);
    an_restart_ack <= 1'b1;
    @(posedge clk);
    an_restart_ack <= 1'b0;
    rdc(PPC_OFF_CTL, 16'h0000);
    wr(PPC_OFF_BMC, 2'h3, 16'h0200);
    check(an_restart_pulse, 1'b1);
    @(posedge clk);
    an_restart_ack <= 1'b1;
    @(posedge clk);
    an_restart_ack <= 1'b0;
    rdc(PPC_OFF_CTL, 16'h0000);
  endtask

  task automatic s_status;
    @(posedge clk);
    partner_ability <= 5'h15;
    link_speed_100  <= 1'b1;
    mdi_status      <= 1'b1;
    link_good       <= 1'b1;
    rdc(PPC_OFF_STS, 16'h04B5);
    rdc(PPC_OFF_LPA, 16'h04A1);
    @(posedge clk);
    partner_ability  <= 5'h0A;
    link_speed_100   <= 1'b0;
    link_full_duplex <= 1'b1;
    mdi_status       <= 1'b0;
    an_done          <= 1'b1;
    link_good        <= 1'b0;
    rdc(PPC_OFF_STS, 16'h024A);
    rdc(PPC_OFF_LPA, 16'h0141);
  endtask

  // Unmapped place and frozen clock enable must leave the fields alone
  task automatic s_refuse;
    rdc(8'hF0, 16'h0000);
    wr(8'hF0, 2'h3, 16'hFFFF);
    rdc(PPC_OFF_CTL, 16'h0000);
    @(posedge clk);
    clk_en <= 1'b0;
    wr(PPC_OFF_CTL, 2'h3, 16'h4000);
    @(posedge clk);
    clk_en <= 1'b1;
    #1;
    check(tx_disable, 1'b0);
    rdc(PPC_OFF_CTL, 16'h0000);
  endtask

  initial begin
    s_reset();
    s_fields();
    s_mirror();
    s_led();
    s_restart();
    s_status();
    s_refuse();
    s_reset();
    close_out();
  end
endmodule
`default_nettype wire
